// >>> hdl/mrs_pkg.sv
// Constants, types and register map of the serial register slave
package mrs_pkg;
   // ----------------------------------------
   // Function codes and register map
   // ----------------------------------------
   localparam logic [7:0]  FC_RD_HOLD      = 8'h03;
   localparam logic [7:0]  FC_RD_IN        = 8'h04;
   localparam logic [7:0]  FC_WR_MULTI     = 8'h10;
   localparam logic [7:0]  FC_RD_WR        = 8'h17;
   localparam logic [15:0] REG_ACTION      = 16'h03E8;
   localparam logic [15:0] REG_POSITION    = 16'h03E9;
   localparam logic [15:0] REG_SPEED_FORCE = 16'h03EA;
   localparam logic [15:0] REG_OUT_SPARE   = 16'h03EB;
   localparam logic [15:0] REG_STATUS      = 16'h07D0;
   localparam logic [15:0] REG_FAULT_ECHO  = 16'h07D1;
   localparam logic [15:0] REG_RESET       = 16'h0000;
   localparam int          OUT_WORDS       = 4;
   localparam int          BUF_BYTES       = 32;
   localparam int          MAX_READ        = 8;
   localparam logic [7:0]  DEF_SLAVE_ID    = 8'h09;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int ACT_REQ_BIT  = 8;
   localparam int GOTO_REQ_BIT = 11;
   localparam int ST_ACT_BIT   = 0;
   localparam int ST_GOTO_BIT  = 3;
   localparam int ST_STATE_LSB = 4;
   localparam int ST_OBJ_LSB   = 6;
   // ----------------------------------------
   // Frame layout and checksum
   // ----------------------------------------
   localparam logic [15:0] CRC_INIT    = 16'hFFFF;
   localparam logic [15:0] CRC_POLY    = 16'hA001;
   localparam int          RD_REQ_LEN  = 8;
   localparam int          WR_HDR_LEN  = 9;
   localparam int          RW_HDR_LEN  = 13;
   localparam int          WR_DATA_OFS = 7;
   localparam int          RW_DATA_OFS = 11;
   localparam int          WR_ACK_LEN  = 6;
   localparam int          RD_HDR_LEN  = 3;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam longint BIT_RATE      = 115200;
   localparam longint CHAR_BITS     = 10;
   localparam longint GAP_CHAR_X10  = 35;
   localparam longint CLK_PERIOD_NS = 40;
   localparam longint GAP_NS        = (GAP_CHAR_X10 * CHAR_BITS * 64'd100000000 + BIT_RATE - 1) / BIT_RATE;
   localparam int     GAP_CYC       = int'((GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_CHECK = 2'b01,
      ST_WRITE = 2'b10,
      ST_SEND  = 2'b11
   } mrs_state_e;
   typedef struct packed {
      logic [1:0] obj;
      logic [1:0] act_state;
      logic [7:0] fault;
   } mrs_stat_s;
   typedef struct packed {
      logic [15:0] action;
      logic [15:0] position;
      logic [15:0] speed_force;
      logic [15:0] spare;
   } mrs_out_s;
   typedef struct packed {
      mrs_state_e                         st;
      logic [BUF_BYTES-1:0][7:0]          rx_buf;
      logic [5:0]                         len;
      logic                               ovf;
      logic [15:0]                        gap;
      logic [15:0]                        crc;
      logic [7:0]                         fn;
      logic [15:0]                        rd_a;
      logic [3:0]                         rd_n;
      logic [15:0]                        wr_a;
      logic [15:0]                        wr_n;
      logic [5:0]                         dofs;
      logic [5:0]                         tidx;
      logic [5:0]                         tlen;
      logic [15:0]                        tcrc;
      logic [7:0]                         tx_b;
      logic [OUT_WORDS-1:0][15:0]         regs;
      logic                               act_echo;
      logic                               act_pulse;
   } mrs_reg_s;
endpackage

// >>> hdl/mrs_slave.sv
// Serial register slave: frame parser, register window and reply generator
//
// Operation
// - Combined read-write applies written values and returns read contents together.
// - Combined frame: address, 0x17, read start/count, write start/count, bytes, data, check.
// - Combined reply: address, 0x17, twice read count, words in order, check.
// - Words 0x07D0 and 0x07D1 hold status, object, fault and position echo.
// - Writes to 0x03E9 and 0x03EA set position, speed and force.
// - Replies carry live register values, not frozen copies.
// - Preset write of three words starts 0x03E8, count 3, six bytes.
// - Preset write acknowledged with address, 0x10, start, count and check only.
// - Activation latched only on a cleared-to-set transition of the request bit.
// - One-word holding read answered with 0x03, count 02, two bytes, check.
// - Status first byte is gripper status, second reads zero; 0x11 means activating.
// - Every frame ends with a two-byte check over preceding bytes.
// - Addresses travel high byte first; data words carry gripper byte 0 first.
`timescale 1ns/1ps
module mrs_slave
   import mrs_pkg::*;
#(
   parameter int         GAP_CYCLES = GAP_CYC,
   parameter logic [7:0] SLAVE_ID   = DEF_SLAVE_ID
) (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic [7:0] rx_byte_i,
   input  wire logic       rx_valid_i,
   output logic      [7:0] tx_byte_o,
   output logic            tx_valid_o,
   input  wire logic       tx_ready_i,
   input  wire mrs_stat_s  stat_i,
   output mrs_out_s        regs_o,
   output logic            act_echo_o,
   output logic            act_start_o,
   output logic            busy_o
);
   mrs_reg_s r;
   mrs_reg_s next_r;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] x;
      x = c ^ {8'h00, b};
      for (int k = 0; k < 8; k++) begin
         x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
      end
      return x;
   endfunction

   // Live view of the input window, gripper byte 0 in the high half
   function automatic logic [15:0] rd_word(input mrs_reg_s s, input mrs_stat_s st, input logic [15:0] a);
      logic [7:0] sb;
      sb = 8'h00;
      sb[ST_ACT_BIT] = s.act_echo;
      sb[ST_GOTO_BIT] = s.regs[0][GOTO_REQ_BIT];
      sb[ST_STATE_LSB+:2] = st.act_state;
      sb[ST_OBJ_LSB+:2] = st.obj;
      if (a == REG_STATUS) begin
         return {sb, 8'h00};
      end else if (a == REG_FAULT_ECHO) begin
         return {st.fault, s.regs[1][7:0]};
      end else begin
         return 16'h0000;
      end
   endfunction

   function automatic logic [7:0] rsp_byte(input mrs_reg_s s, input mrs_stat_s st, input logic [5:0] i);
      logic [5:0]  k;
      logic [15:0] w;
      k = (i - 6'(RD_HDR_LEN)) >> 1;
      w = rd_word(s, st, s.rd_a + {12'h000, k[3:0]});
      if (i == 6'd0) begin
         return SLAVE_ID;
      end else if (i == 6'd1) begin
         return s.fn;
      end else if (s.fn == FC_WR_MULTI) begin
         return s.rx_buf[i[4:0]];
      end else if (i == 6'd2) begin
         return {3'b000, s.rd_n, 1'b0};
      end else begin
         return i[0] ? w[15:8] : w[7:0];
      end
   endfunction

   // ----------------------------------------
   // Decode of a completed frame
   // ----------------------------------------
   logic        dec_ok;
   logic [15:0] dec_rd_a;
   logic [15:0] dec_rd_n;
   logic [15:0] dec_wr_a;
   logic [15:0] dec_wr_n;
   logic [8:0]  dec_bc;
   logic [5:0]  dec_ofs;
   logic [8:0]  len9;
   always_comb begin
      len9 = {3'b000, r.len};
      dec_ok = 1'b0;
      dec_rd_a = {r.rx_buf[2], r.rx_buf[3]};
      dec_rd_n = {r.rx_buf[4], r.rx_buf[5]};
      dec_wr_a = {r.rx_buf[2], r.rx_buf[3]};
      dec_wr_n = 16'h0000;
      dec_bc = {1'b0, r.rx_buf[6]};
      dec_ofs = 6'(WR_DATA_OFS);
      if (r.fn == FC_RD_HOLD || r.fn == FC_RD_IN) begin
         dec_ok = len9 == 9'(RD_REQ_LEN) && dec_rd_n != 16'h0000 && dec_rd_n <= 16'(MAX_READ);
      end else if (r.fn == FC_WR_MULTI) begin
         dec_wr_n = dec_rd_n;
         dec_rd_n = 16'h0000;
         dec_ok = len9 == dec_bc + 9'(WR_HDR_LEN) && dec_wr_n != 16'h0000
                  && {7'h00, dec_bc} == {dec_wr_n[14:0], 1'b0};
      end else if (r.fn == FC_RD_WR) begin
         dec_wr_a = {r.rx_buf[6], r.rx_buf[7]};
         dec_wr_n = {r.rx_buf[8], r.rx_buf[9]};
         dec_bc = {1'b0, r.rx_buf[10]};
         dec_ofs = 6'(RW_DATA_OFS);
         dec_ok = len9 == dec_bc + 9'(RW_HDR_LEN) && dec_wr_n != 16'h0000
                  && {7'h00, dec_bc} == {dec_wr_n[14:0], 1'b0}
                  && dec_rd_n != 16'h0000 && dec_rd_n <= 16'(MAX_READ);
      end
      dec_ok = dec_ok && !r.ovf && r.crc == 16'h0000 && r.rx_buf[0] == SLAVE_ID;
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [15:0] off;
      logic [5:0]  bi;
      logic [15:0] ucrc;
      off = 16'h0000;
      bi = 6'd0;
      ucrc = crc_upd(r.tcrc, r.tx_b);
      next_r = r;
      next_r.act_pulse = 1'b0;
      case (r.st)
         ST_IDLE: begin
            if (rx_valid_i) begin
               if (r.len < 6'(BUF_BYTES)) begin
                  next_r.rx_buf[r.len[4:0]] = rx_byte_i;
                  next_r.len = r.len + 6'd1;
               end else begin
                  next_r.ovf = 1'b1;
               end
               next_r.crc = crc_upd(r.crc, rx_byte_i);
               next_r.gap = 16'h0000;
            end else if (r.len != 6'd0) begin
               if (r.gap == 16'(GAP_CYCLES - 1)) begin
                  next_r.st = ST_CHECK;
                  next_r.fn = r.rx_buf[1];
               end else begin
                  next_r.gap = r.gap + 16'h0001;
               end
            end
         end
         ST_CHECK: begin
            next_r.rd_a = dec_rd_a;
            next_r.rd_n = dec_rd_n[3:0];
            next_r.wr_a = dec_wr_a;
            next_r.wr_n = dec_wr_n;
            next_r.dofs = dec_ofs;
            next_r.st = dec_ok ? ST_WRITE : ST_IDLE;
            if (!dec_ok) begin
               next_r.len = 6'd0;
               next_r.ovf = 1'b0;
               next_r.gap = 16'h0000;
               next_r.crc = CRC_INIT;
            end
         end
         ST_WRITE: begin
            for (int w = 0; w < OUT_WORDS; w++) begin
               off = REG_ACTION + 16'(w) - r.wr_a;
               bi = r.dofs + {off[4:0], 1'b0};
               if (REG_ACTION + 16'(w) >= r.wr_a && off < r.wr_n) begin
                  next_r.regs[w] = {r.rx_buf[bi[4:0]], r.rx_buf[bi[4:0] + 5'd1]};
               end
            end
            // Edge only: a held request must not restart activation
            if (next_r.regs[0][ACT_REQ_BIT] && !r.regs[0][ACT_REQ_BIT]) begin
               next_r.act_echo = 1'b1;
               next_r.act_pulse = 1'b1;
            end else if (!next_r.regs[0][ACT_REQ_BIT]) begin
               next_r.act_echo = 1'b0;
            end
            next_r.st = ST_SEND;
            next_r.tidx = 6'd0;
            next_r.tcrc = CRC_INIT;
            next_r.tx_b = SLAVE_ID;
            next_r.tlen = (r.fn == FC_WR_MULTI) ? 6'(WR_ACK_LEN)
                        : 6'(RD_HDR_LEN) + {1'b0, r.rd_n, 1'b0};
         end
         ST_SEND: begin
            if (tx_ready_i) begin
               next_r.tidx = r.tidx + 6'd1;
               if (r.tidx == r.tlen + 6'd1) begin
                  next_r.st = ST_IDLE;
                  next_r.len = 6'd0;
                  next_r.ovf = 1'b0;
                  next_r.gap = 16'h0000;
                  next_r.crc = CRC_INIT;
               end else if (r.tidx == r.tlen) begin
                  next_r.tx_b = r.tcrc[15:8];
               end else begin
                  next_r.tcrc = ucrc;
                  // Reply bytes fetched one at a time, so status stays current
                  next_r.tx_b = (r.tidx + 6'd1 == r.tlen) ? ucrc[7:0]
                              : rsp_byte(r, stat_i, r.tidx + 6'd1);
               end
            end
         end
         default: next_r.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         r <= '0;
         r.crc <= CRC_INIT;
         r.tcrc <= CRC_INIT;
         r.regs <= {OUT_WORDS{REG_RESET}};
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign tx_byte_o = r.tx_b;
   assign tx_valid_o = r.st == ST_SEND;
   assign busy_o = r.st != ST_IDLE;
   assign act_echo_o = r.act_echo;
   assign act_start_o = r.act_pulse;
   assign regs_o.action = r.regs[0];
   assign regs_o.position = r.regs[1];
   assign regs_o.speed_force = r.regs[2];
   assign regs_o.spare = r.regs[3];

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   tx_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
      else $error("reply byte changed under back-pressure");
   first_addr_a: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(tx_valid_o) |-> tx_byte_o == SLAVE_ID)
      else $error("reply does not open with slave address");
   fn_echo_a: assert property (@(posedge clk_i) disable iff (reset_i)
      tx_valid_o && r.tidx == 6'd1 |-> tx_byte_o == r.fn)
      else $error("reply function code wrong");
   rd_count_a: assert property (@(posedge clk_i) disable iff (reset_i)
      tx_valid_o && r.tidx == 6'd2 && r.fn != FC_WR_MULTI |-> tx_byte_o == {3'b000, r.rd_n, 1'b0})
      else $error("read byte count not twice word count");
   rsv_zero_a: assert property (@(posedge clk_i) disable iff (reset_i)
      tx_valid_o && r.tidx == 6'd4 && r.fn != FC_WR_MULTI && r.rd_a == REG_STATUS |-> tx_byte_o == 8'h00)
      else $error("reserved status byte not zero");
   act_edge_a: assert property (@(posedge clk_i) disable iff (reset_i)
      act_start_o |-> act_echo_o && r.regs[0][ACT_REQ_BIT] && !$past(r.regs[0][ACT_REQ_BIT]) ##1 !act_start_o)
      else $error("activation started without a rising request");
   gap_end_a: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(r.st == ST_CHECK) |-> !$past(rx_valid_i) && $past(r.gap) == 16'(GAP_CYCLES - 1))
      else $error("frame closed before silence elapsed");
   drop_bad_a: assert property (@(posedge clk_i) disable iff (reset_i)
      r.st == ST_CHECK && (r.crc != 16'h0000 || r.rx_buf[0] != SLAVE_ID) |=> r.st == ST_IDLE ##1 !tx_valid_o)
      else $error("bad frame not dropped");
   rw_reply_a: assert property (@(posedge clk_i) disable iff (reset_i)
      r.st == ST_WRITE |=> tx_valid_o && r.tlen != 6'd0)
      else $error("accepted frame got no reply");
   frame_end_a: assert property (@(posedge clk_i) disable iff (reset_i)
      tx_valid_o && tx_ready_i && r.tidx == r.tlen + 6'd1 |=> !tx_valid_o && r.len == 6'd0)
      else $error("reply did not end after check bytes");
endmodule

// >>> verif/mrs_master.sv
// Behavioural model of the line master that talks to the register slave
`timescale 1ns/1ps
module mrs_master (
   input  wire logic       clk_i,
   output logic      [7:0] rx_byte_o,
   output logic            rx_valid_o,
   input  wire logic [7:0] tx_byte_i,
   input  wire logic       tx_valid_i,
   output logic            tx_ready_o
);
   initial begin
      rx_byte_o = 8'h5A;
      rx_valid_o = 1'b0;
      tx_ready_o = 1'b0;
   end
   // ----------------------------------------
   // Frame check and byte transfer
   // ----------------------------------------
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      return c;
   endfunction
   // Bytes go out exactly as the bench laid them out: addresses high first, data as given
   task automatic send(input logic [7:0] f[$], input int space);
      // Pause between commands, scaled down like the frame gap
      repeat (80) @(negedge clk_i);
      foreach (f[i]) begin
         @(negedge clk_i);
         rx_byte_o = f[i];
         rx_valid_o = 1'b1;
         repeat (space) begin
            @(negedge clk_i);
            rx_valid_o = 1'b0;
            rx_byte_o = ~f[i];
         end
      end
      @(negedge clk_i);
      rx_valid_o = 1'b0;
      rx_byte_o = ~rx_byte_o;
   endtask
   // Slow mode accepts only every third cycle to stretch the reply
   task automatic recv(input int n, input bit slow, output logic [7:0] r[$]);
      int k;
      r = {};
      k = 0;
      while (r.size() < n && k < 400) begin
         @(negedge clk_i);
         tx_ready_o = !slow || (k % 3 == 2);
         // Registered outputs: the mid-cycle view is what the next edge takes
         if (tx_valid_i && tx_ready_o) r.push_back(tx_byte_i);
         @(posedge clk_i);
         k++;
      end
      @(negedge clk_i);
      tx_ready_o = 1'b0;
   endtask
endmodule

// >>> verif/tb.sv
// Self-checking bench of the serial register slave
`timescale 1ns/1ps
module tb;
   import mrs_pkg::*;
   localparam int GAP = 20;
   logic       clk_i = 1'b0;
   logic       reset_i = 1'b1;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;
   logic       rx_valid;
   logic       tx_valid;
   logic       tx_ready;
   logic       act_echo;
   logic       act_start;
   logic       busy;
   mrs_stat_s  stat = '0;
   mrs_out_s   regs;
   int         num_errors = 0;
   int         total_checks = 0;
   int         cycles = 0;
   int         starts = 0;

   mrs_slave #(.GAP_CYCLES(GAP)) mrs_slave_i (.clk_i(clk_i), .reset_i(reset_i), .rx_byte_i(rx_byte),
      .rx_valid_i(rx_valid), .tx_byte_o(tx_byte), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
      .stat_i(stat), .regs_o(regs), .act_echo_o(act_echo), .act_start_o(act_start), .busy_o(busy));
   mrs_master mrs_master_i (.clk_i(clk_i), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
      .tx_byte_i(tx_byte), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));

   always #20 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (act_start === 1'b1) starts <= starts + 1;
      if (cycles == 20000) begin
         num_errors++;
         conclude();
      end
   end
   // ----------------------------------------
   // Shared helpers
   // ----------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic seal(inout logic [7:0] q[$]);
      logic [15:0] c;
      c = mrs_master_i.crc16(q);
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
   endtask
   task automatic quiet(input int n, output int hits);
      hits = 0;
      repeat (n) @(negedge clk_i) hits += (tx_valid !== 1'b0);
   endtask
   task automatic xfer(input logic [7:0] f[$], input logic [7:0] e[$], input bit slow);
      logic [7:0] r[$];
      int         h;
      mrs_master_i.send(f, slow ? 2 : 0);
      quiet(GAP - 1, h);
      check(h, 0);
      mrs_master_i.recv(e.size(), slow, r);
      check(r.size(), e.size());
      foreach (e[i]) check(r[i], e[i]);
      check(mrs_master_i.crc16(r), 16'h0000);
      check(busy, 0);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      check(regs, 64'h0);
      check({act_echo, act_start, busy, tx_valid, tx_byte}, 12'h000);
      $display("done reset");
   endtask
   task automatic t_rearm();
      reset_i = 1'b1;
      repeat (2) @(negedge clk_i);
      reset_i = 1'b0;
      @(negedge clk_i);
      t_reset();
      xfer('{8'h09, 8'h10, 8'h03, 8'hE8, 8'h00, 8'h03, 8'h06, 8'h01, 0, 0, 0, 0, 0, 8'h72, 8'hE1},
           '{8'h09, 8'h10, 8'h03, 8'hE8, 8'h00, 8'h03, 8'h01, 8'h30}, 0);
      check({starts, act_echo}, {32'd2, 1'b1});
      $display("done rearm");
   endtask
   task automatic t_activate();
      logic [7:0] ack[$];
      ack = '{8'h09, 8'h10, 8'h03, 8'hE8, 8'h00, 8'h03, 8'h01, 8'h30};
      xfer('{8'h09, 8'h10, 8'h03, 8'hE8, 8'h00, 8'h03, 8'h06, 0, 0, 0, 0, 0, 0, 8'h73, 8'h30}, ack, 0);
      check({starts, act_echo}, 0);
      for (int i = 0; i < 2; i++) begin
         xfer('{8'h09, 8'h10, 8'h03, 8'hE8, 8'h00, 8'h03, 8'h06, 8'h01, 0, 0, 0, 0, 0, 8'h72, 8'hE1}, ack, i);
         check({starts, act_echo, regs.action}, {32'd1, 1'b1, 16'h0100});
      end
      $display("done activate");
   endtask
   task automatic t_poll();
      stat = '{obj: 2'd0, act_state: 2'd1, fault: 8'h00};
      xfer('{8'h09, 8'h03, 8'h07, 8'hD0, 8'h00, 8'h01, 8'h85, 8'hCF}, '{8'h09, 8'h03, 8'h02, 8'h11, 8'h00, 8'h55, 8'hD5}, 0);
      stat.act_state = 2'd3;
      xfer('{8'h09, 8'h03, 8'h07, 8'hD0, 8'h00, 8'h01, 8'h85, 8'hCF}, '{8'h09, 8'h03, 8'h02, 8'h31, 8'h00, 8'h4C, 8'h15}, 1);
      $display("done poll");
   endtask
   task automatic t_combined();
      stat = '{obj: 2'd0, act_state: 2'd0, fault: 8'h09};
      xfer('{8'h09, 8'h17, 8'h07, 8'hD0, 8'h00, 8'h02, 8'h03, 8'hE9, 8'h00, 8'h02, 8'h04, 8'h00, 8'hE6,
             8'h3C, 8'hC8, 8'h2D, 8'h0C}, '{8'h09, 8'h17, 8'h04, 8'h01, 8'h00, 8'h09, 8'hE6, 8'hF6, 8'hC1}, 1);
      check({regs.position, regs.speed_force}, 32'h00E63CC8);
      $display("done combined");
   endtask
   task automatic t_preset();
      logic [7:0] f[$];
      logic [7:0] e[$];
      xfer('{8'h09, 8'h10, 8'h03, 8'hE8, 8'h00, 8'h03, 8'h06, 8'h09, 0, 0, 8'hFF, 8'hFF, 8'hFF, 8'h42, 8'h29},
           '{8'h09, 8'h10, 8'h03, 8'hE8, 8'h00, 8'h03, 8'h01, 8'h30}, 0);
      check({regs.action, regs.position, regs.speed_force}, 48'h090000FFFFFF);
      check(starts, 1);
      stat = '{obj: 2'd2, act_state: 2'd3, fault: 8'h00};
      f = '{8'h09, 8'h04, 8'h07, 8'hD0, 8'h00, 8'h01};
      seal(f);
      e = '{8'h09, 8'h04, 8'h02, 8'hB9, 8'h00};
      seal(e);
      xfer(f, e, 0);
      $display("done preset");
   endtask
   task automatic t_drop();
      logic [7:0] f[$];
      int         h;
      f = '{8'h0A, 8'h03, 8'h07, 8'hD0, 8'h00, 8'h01};
      seal(f);
      mrs_master_i.send(f, 0);
      quiet(GAP + 10, h);
      check(h, 0);
      f = '{8'h09, 8'h03, 8'h07, 8'hD0, 8'h00, 8'h09};
      seal(f);
      mrs_master_i.send(f, 0);
      quiet(GAP + 10, h);
      check(h, 0);
      mrs_master_i.send('{8'h09, 8'h10, 8'h03, 8'hE8, 8'h00, 8'h03, 8'h06, 0, 0, 0, 0, 0, 0, 8'h73, 8'h31}, 0);
      quiet(GAP + 10, h);
      check({h, regs.action, act_echo}, {32'd0, 16'h0900, 1'b1});
      $display("done drop");
   endtask

   initial begin
      repeat (16) @(negedge clk_i);
      reset_i = 1'b0;
      @(negedge clk_i);
      t_reset();
      t_activate();
      t_poll();
      t_combined();
      t_preset();
      t_drop();
      t_rearm();
      conclude();
   end
endmodule
